// *** design/overcurrent_element_logic.sv ***
// Purpose: Nondirectional overcurrent elements with APB settings
// Assumes: Phasor inputs are fundamental-only estimates on pclk
// Notes:   Magnitudes compared squared to avoid square roots
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "oc_cfg.svh"
//
// Contract
// - Comparisons use only fundamental phasor magnitudes, harmonics already removed.
// - Wye connection makes phase, negative-sequence and residual elements available.
// - Delta connection keeps phase and negative-sequence only, no residual elements.
// - Max elements use largest phase magnitude; phase elements compare each phase.
// - Three max-phase instantaneous levels, each with its own pickup.
// - Max instantaneous output follows highest phase; no torque gating.
// - Each phase has two instantaneous levels with own pickups, ungated.
// - Two ungated levels each for negative-sequence 3I2 and residual sum.
// - Inverse-time elements for max, phases A, B, C, negseq, residual.
// - Each inverse-time element gives trip, pickup and reset-state bits.
// - Torque bit: constant one active, zero disabled, or external equation.
// - Each inverse-time element has pickup, curve, time dial, reset style.
// - Every element holds its own pickup; only inverse-time elements have delay settings.
// - Pickup set to OFF never asserts and other settings are ignored.
// - Fast reset clears an element one power cycle below pickup.
// - Disk reset emulates gradual spring-governed reset instead.
module overcurrent_element_logic #(
  parameter int CYC_TICKS = `OC_CYC_TICKS
) (
  // APB
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Fundamental phasors, one set per processing interval
  input  wire logic                  sample_valid,
  input  wire logic signed [`OC_PH_W-1:0] ia_re,
  input  wire logic signed [`OC_PH_W-1:0] ia_im,
  input  wire logic signed [`OC_PH_W-1:0] ib_re,
  input  wire logic signed [`OC_PH_W-1:0] ib_im,
  input  wire logic signed [`OC_PH_W-1:0] ic_re,
  input  wire logic signed [`OC_PH_W-1:0] ic_im,
  // Torque equation results
  input  wire logic [`OC_N_TOC-1:0]  torque_ext,
  // Element outputs
  output logic [`OC_N_INST-1:0]      inst_out,
  output logic [`OC_N_TOC-1:0]       inverse_time_trip_out,
  output logic [`OC_N_TOC-1:0]       toc_pickup_out,
  output logic [`OC_N_TOC-1:0]       inverse_time_reset_out,
  output logic                       irq
);
  // Settings
  logic                       wye;
  logic [`OC_TCM_W-1:0]       tc_mode;
  oc_pkg::pu_t                ipu [`OC_N_INST];
  oc_pkg::pu_t                inverse_time_pickup [`OC_N_TOC];
  logic [`OC_CURVE_W-1:0]     curve_shape_setting [`OC_N_TOC];
  logic [`OC_DIAL_W-1:0]      time_dial_setting [`OC_N_TOC];
  logic                       reset_style_select [`OC_N_TOC];
  logic [`OC_N_EV-1:0]        int_st;
  logic [`OC_N_EV-1:0]        int_msk;

  // Bus decode
  logic                       apb_wr;
  logic                       apb_rd;
  logic                       apb_setup;
  logic [31:0]                next_rdata;
  logic                       next_err;

  // Measurement pipeline
  logic                       mag_tick;
  oc_pkg::mag_t               mag_a;
  oc_pkg::mag_t               mag_b;
  oc_pkg::mag_t               mag_c;
  oc_pkg::mag_t               mag_q;
  oc_pkg::mag_t               mag_g;
  oc_pkg::mag_t               mag_max;
  oc_pkg::mag_t               toc_mag [`OC_N_TOC];
  logic [`OC_N_INST-1:0]      next_inst;
  logic [`OC_N_INST-1:0]      inst_prev;
  logic [`OC_N_TOC-1:0]       trip_prev;
  logic [`OC_N_EV-1:0]        ev;
  logic [`OC_N_EV-1:0]        clr_mask;

  function automatic oc_pkg::ext_t ext(input logic signed [`OC_PH_W-1:0] x);
    return oc_pkg::ext_t'(x);
  endfunction

  function automatic oc_pkg::ext_t s60(input oc_pkg::ext_t x);
    logic signed [31:0] p;
    p = 32'(x) * `OC_SIN60;
    p = p >>> `OC_SIN60_SH;
    return p[`OC_EXT_W-1:0];
  endfunction

  function automatic oc_pkg::mag_t msq(input oc_pkg::ext_t re, input oc_pkg::ext_t im);
    logic signed [`OC_MAG_W-1:0] p;
    logic signed [`OC_MAG_W-1:0] q;
    p = `OC_MAG_W'(re) * `OC_MAG_W'(re);
    q = `OC_MAG_W'(im) * `OC_MAG_W'(im);
    return oc_pkg::mag_t'(p + q);
  endfunction

  function automatic oc_pkg::mag_t pusq(input oc_pkg::pu_t p);
    return oc_pkg::mag_t'(p) * oc_pkg::mag_t'(p);
  endfunction

  // OFF pickup never asserts
  function automatic logic over(input oc_pkg::mag_t m, input oc_pkg::pu_t p);
    return (p != '0) && (m > pusq(p));
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int n);
    return (a >= base) && (a < base + 8'(n) * `OC_WORD) && (a[1:0] == 2'b00);
  endfunction

  function automatic int widx(input logic [7:0] a, input logic [7:0] base);
    return int'((a - base) / `OC_WORD);
  endfunction

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign apb_rd    = psel && penable && !pwrite;
  // Every access ends in one access cycle
  assign pready    = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wye     <= `OC_RST_WYE;
      tc_mode <= `OC_RST_TCM;
      int_msk <= '0;
      for (int i = 0; i < `OC_N_INST; i++) begin
        ipu[i] <= '0;
      end
      for (int k = 0; k < `OC_N_TOC; k++) begin
        inverse_time_pickup[k] <= '0;
        curve_shape_setting[k] <= '0;
        time_dial_setting[k]   <= '0;
        reset_style_select[k]  <= 1'b0;
      end
    end else if (apb_wr) begin
      if (paddr == `OC_A_CTRL) begin
        wye <= pwdata[`OC_F_WYE];
      end
      if (paddr == `OC_A_TCMODE) begin
        tc_mode <= pwdata[`OC_TCM_W-1:0];
      end
      if (paddr == `OC_A_INTMSK) begin
        int_msk <= pwdata[`OC_N_EV-1:0];
      end
      for (int i = 0; i < `OC_N_INST; i++) begin
        if (paddr == `OC_A_IPU + 8'(i) * `OC_WORD) begin
          ipu[i] <= pwdata[`OC_PU_W-1:0];
        end
      end
      for (int k = 0; k < `OC_N_TOC; k++) begin
        if (paddr == `OC_A_TPU + 8'(k) * `OC_WORD) begin
          inverse_time_pickup[k] <= pwdata[`OC_PU_W-1:0];
        end
        if (paddr == `OC_A_TSET + 8'(k) * `OC_WORD) begin
          time_dial_setting[k]   <= pwdata[`OC_DIAL_W-1:0];
          curve_shape_setting[k] <= pwdata[`OC_F_CURVE +: `OC_CURVE_W];
          reset_style_select[k]  <= pwdata[`OC_F_RS];
        end
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (paddr == `OC_A_CTRL) begin
      next_rdata[`OC_F_WYE] = wye;
    end else if (paddr == `OC_A_TCMODE) begin
      next_rdata[`OC_TCM_W-1:0] = tc_mode;
    end else if (hit(paddr, `OC_A_IPU, `OC_N_INST)) begin
      next_rdata[`OC_PU_W-1:0] = ipu[widx(paddr, `OC_A_IPU)];
    end else if (hit(paddr, `OC_A_TPU, `OC_N_TOC)) begin
      next_rdata[`OC_PU_W-1:0] = inverse_time_pickup[widx(paddr, `OC_A_TPU)];
    end else if (hit(paddr, `OC_A_TSET, `OC_N_TOC)) begin
      next_rdata[`OC_DIAL_W-1:0]             = time_dial_setting[widx(paddr, `OC_A_TSET)];
      next_rdata[`OC_F_CURVE +: `OC_CURVE_W] = curve_shape_setting[widx(paddr, `OC_A_TSET)];
      next_rdata[`OC_F_RS]                   = reset_style_select[widx(paddr, `OC_A_TSET)];
    end else if (paddr == `OC_A_ISTAT) begin
      next_rdata[`OC_N_INST-1:0] = inst_out;
    end else if (paddr == `OC_A_TSTAT) begin
      next_rdata[`OC_N_TOC-1:0]                 = inverse_time_trip_out;
      next_rdata[`OC_F_TPICK +: `OC_N_TOC]      = toc_pickup_out;
      next_rdata[`OC_F_TRST +: `OC_N_TOC]       = inverse_time_reset_out;
    end else if (paddr == `OC_A_INTST) begin
      next_rdata[`OC_N_EV-1:0] = int_st;
    end else if (paddr == `OC_A_INTMSK) begin
      next_rdata[`OC_N_EV-1:0] = int_msk;
    end else begin
      next_err = 1'b1;
    end
  end

  // Answer is captured in setup so the access cycle sees stable data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= next_err;
    end
  end

  // Magnitudes from fundamental phasors only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mag_tick <= 1'b0;
      mag_a    <= '0;
      mag_b    <= '0;
      mag_c    <= '0;
      mag_q    <= '0;
      mag_g    <= '0;
    end else begin
      mag_tick <= sample_valid;
      if (sample_valid) begin
        mag_a <= msq(ext(ia_re), ext(ia_im));
        mag_b <= msq(ext(ib_re), ext(ib_im));
        mag_c <= msq(ext(ic_re), ext(ic_im));
        mag_g <= msq(ext(ia_re) + ext(ib_re) + ext(ic_re),
                     ext(ia_im) + ext(ib_im) + ext(ic_im));
        mag_q <= msq(ext(ia_re) - (ext(ib_re) >>> 1) + s60(ext(ib_im))
                     - (ext(ic_re) >>> 1) - s60(ext(ic_im)),
                     ext(ia_im) - s60(ext(ib_re)) - (ext(ib_im) >>> 1)
                     + s60(ext(ic_re)) - (ext(ic_im) >>> 1));
      end
    end
  end

  // Largest phase drives the max elements
  always_comb begin
    mag_max = mag_a;
    if (mag_b > mag_max) begin
      mag_max = mag_b;
    end
    if (mag_c > mag_max) begin
      mag_max = mag_c;
    end
  end

  // No torque gating on instantaneous elements
  always_comb begin
    next_inst[0]  = over(mag_max, ipu[0]);
    next_inst[1]  = over(mag_max, ipu[1]);
    next_inst[2]  = over(mag_max, ipu[2]);
    next_inst[3]  = over(mag_a, ipu[3]);
    next_inst[4]  = over(mag_b, ipu[4]);
    next_inst[5]  = over(mag_c, ipu[5]);
    next_inst[6]  = over(mag_a, ipu[6]);
    next_inst[7]  = over(mag_b, ipu[7]);
    next_inst[8]  = over(mag_c, ipu[8]);
    next_inst[9]  = over(mag_q, ipu[9]);
    next_inst[10] = over(mag_q, ipu[10]);
    next_inst[11] = wye && over(mag_g, ipu[11]);
    next_inst[12] = wye && over(mag_g, ipu[12]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inst_out <= '0;
    end else if (mag_tick) begin
      inst_out <= next_inst;
    end
  end

  assign toc_mag[0] = mag_max;
  assign toc_mag[1] = mag_a;
  assign toc_mag[2] = mag_b;
  assign toc_mag[3] = mag_c;
  assign toc_mag[4] = mag_q;
  assign toc_mag[5] = mag_g;

  toc_if tif [`OC_N_TOC] ();

  for (genvar k = 0; k < `OC_N_TOC; k++) begin : g_toc
    logic [1:0] mode;
    assign mode            = tc_mode[2*k +: 2];
    assign tif[k].tick     = mag_tick;
    assign tif[k].mag_sq   = toc_mag[k];
    assign tif[k].pu_sq    = pusq(inverse_time_pickup[k]);
    // Residual element is absent on delta connection
    assign tif[k].off      = (inverse_time_pickup[k] == '0) ||
                             (k == `OC_RES_IDX && !wye);
    assign tif[k].torque   = (mode == oc_pkg::TC_ONE) ||
                             (mode == oc_pkg::TC_EXT && torque_ext[k]);
    assign tif[k].curve    = curve_shape_setting[k];
    assign tif[k].dial     = time_dial_setting[k];
    assign tif[k].disk     = reset_style_select[k];
    assign inverse_time_trip_out[k]  = tif[k].trip;
    assign toc_pickup_out[k]         = tif[k].pick;
    assign inverse_time_reset_out[k] = tif[k].rst;

    toc_element #(
      .CYC_TICKS (CYC_TICKS)
    ) u_toc (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (tif[k])
    );
  end

  // Rising edges of instantaneous and inverse-time trip outputs are interrupt events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inst_prev <= '0;
      trip_prev <= '0;
    end else begin
      inst_prev <= inst_out;
      trip_prev <= inverse_time_trip_out;
    end
  end

  assign ev       = {inverse_time_trip_out & ~trip_prev, inst_out & ~inst_prev};
  // Clear only what the read reported; later events survive
  assign clr_mask = (apb_rd && paddr == `OC_A_INTST) ? prdata[`OC_N_EV-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_st <= '0;
    end else begin
      int_st <= (int_st & ~clr_mask) | ev;
    end
  end

  assign irq = |(int_st & int_msk);

  property p_off_inst;
    @(posedge pclk) disable iff (!presetn)
      (mag_tick && ipu[0] == '0) |=> !inst_out[0];
  endproperty
  a_off_inst: assert property (p_off_inst) else $error("OFF element asserted");

  property p_max;
    @(posedge pclk) disable iff (!presetn)
      (mag_tick && ipu[2] != '0 && mag_c > pusq(ipu[2])) |=> inst_out[2];
  endproperty
  a_max: assert property (p_max) else $error("max level missed highest phase");

  property p_phase;
    @(posedge pclk) disable iff (!presetn)
      (mag_tick && ipu[4] != '0) |=> (inst_out[4] == (mag_b > pusq(ipu[4])));
  endproperty
  a_phase: assert property (p_phase) else $error("phase B level wrong");

  property p_delta;
    @(posedge pclk) disable iff (!presetn)
      (mag_tick && !wye) |=> (!inst_out[11] && !inst_out[12] && !inverse_time_trip_out[`OC_RES_IDX]);
  endproperty
  a_delta: assert property (p_delta) else $error("residual active on delta");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      $rose(inverse_time_trip_out[0]) |-> ##1 int_st[`OC_N_INST];
  endproperty
  a_sticky: assert property (p_sticky) else $error("trip event not latched");

  property p_rdclr;
    @(posedge pclk) disable iff (!presetn)
      (apb_rd && paddr == `OC_A_INTST && ev == '0) |=> (int_st == ($past(int_st) & ~$past(prdata[`OC_N_EV-1:0])));
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("read did not clear status");

  property p_apb_err;
    @(posedge pclk) disable iff (!presetn)
      (apb_setup && paddr == 8'hFC) |=> pslverr;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused");

  c_delta: cover property (@(posedge pclk) disable iff (!presetn) $fell(wye));
  c_irq:   cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // overcurrent_element_logic

// *** design/toc_element.sv ***
// Purpose: One inverse-time overcurrent element
// Assumes: tick is one pclk cycle per processing interval
// Notes:   Curve equations are outside; curve selects accumulation rate
`timescale 1ns/1ps
`include "oc_cfg.svh"
module toc_element #(
  parameter int CYC_TICKS = `OC_CYC_TICKS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings and results
  toc_if.elem      bus
);
  oc_pkg::acc_t acc;
  oc_pkg::acc_t next_acc;
  oc_pkg::acc_t target;
  oc_pkg::acc_t inc;
  logic [7:0]   below_cnt;
  logic         active;
  logic [`OC_ACC_W:0] sum;

  function automatic oc_pkg::acc_t curve_rate(input logic [`OC_CURVE_W-1:0] c);
    return oc_pkg::acc_t'(c) + oc_pkg::acc_t'(1);
  endfunction

  // Accumulate only above pickup with torque active
  assign active = !bus.off && bus.torque && (bus.mag_sq > bus.pu_sq);
  assign target = oc_pkg::acc_t'(bus.dial) << `OC_DIAL_SH;
  assign inc    = curve_rate(bus.curve);
  assign sum    = {1'b0, acc} + {1'b0, inc};

  always_comb begin
    next_acc = acc;
    if (bus.off) begin
      next_acc = '0;
    end else if (active) begin
      next_acc = (sum >= {1'b0, target}) ? target : sum[`OC_ACC_W-1:0];
    end else if (bus.disk) begin
      next_acc = (acc > `OC_DISK_RATE) ? acc - `OC_DISK_RATE : '0;
    end else if (below_cnt == 8'(CYC_TICKS - 1)) begin
      next_acc = '0;
    end
  end

  // Gradual drop would keep counting; counter only serves fast reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      below_cnt <= '0;
    end else if (bus.tick) begin
      if (active || bus.off || below_cnt == 8'(CYC_TICKS - 1)) begin
        below_cnt <= '0;
      end else begin
        below_cnt <= below_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc      <= '0;
      bus.trip <= 1'b0;
      bus.pick <= 1'b0;
      bus.rst  <= 1'b1;
    end else if (bus.tick) begin
      acc      <= next_acc;
      bus.trip <= active && (next_acc >= target);
      bus.pick <= active;
      bus.rst  <= (next_acc == '0);
    end
  end

  property p_fast_reset;
    @(posedge pclk) disable iff (!presetn)
      (bus.tick && !active && !bus.disk && below_cnt == 8'(CYC_TICKS - 1)) |=> (acc == '0);
  endproperty
  a_fast_reset: assert property (p_fast_reset) else $error("fast reset missed");

  property p_disk;
    @(posedge pclk) disable iff (!presetn)
      (bus.tick && !active && !bus.off && bus.disk && acc > `OC_DISK_RATE)
        |=> (acc == $past(acc) - `OC_DISK_RATE);
  endproperty
  a_disk: assert property (p_disk) else $error("disk reset step wrong");

  property p_torque;
    @(posedge pclk) disable iff (!presetn)
      (bus.tick && !bus.torque) |=> (!bus.pick && !bus.trip);
  endproperty
  a_torque: assert property (p_torque) else $error("active without torque");

  property p_trip;
    @(posedge pclk) disable iff (!presetn)
      (bus.tick && active && sum >= {1'b0, target}) |=> bus.trip;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not asserted");

  c_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(bus.trip));
  c_disk: cover property (@(posedge pclk) disable iff (!presetn)
    bus.disk && $fell(bus.pick) ##[1:400] bus.rst);
endmodule // toc_element

// *** pkg/oc_cfg.svh ***
// Purpose: Constants for the overcurrent element logic
// Assumes: APB byte addresses, 32-bit words
// Notes:   Pickup value zero means OFF
`ifndef OC_CFG_SVH
`define OC_CFG_SVH

// Widths and counts
`define OC_PH_W        16
`define OC_EXT_W       20
`define OC_MAG_W       40
`define OC_PU_W        16
`define OC_ACC_W       24
`define OC_DIAL_W      16
`define OC_CURVE_W     4
`define OC_N_INST      13
`define OC_N_TOC       6
`define OC_N_EV        19
`define OC_TCM_W       12

// Fixed-point sin(60) = 887 / 1024
`define OC_SIN60       32'sd887
`define OC_SIN60_SH    10

// Timing
`define OC_CYC_TICKS   16
`define OC_DIAL_SH     8
`define OC_DISK_RATE   24'h000004

// Register byte offsets
`define OC_A_CTRL      8'h00
`define OC_A_TCMODE    8'h04
`define OC_A_IPU       8'h10
`define OC_A_TPU       8'h50
`define OC_A_TSET      8'h70
`define OC_A_ISTAT     8'h90
`define OC_A_TSTAT     8'h94
`define OC_A_INTST     8'h98
`define OC_A_INTMSK    8'h9C
`define OC_WORD        8'h04

// Field positions
`define OC_F_WYE       0
`define OC_F_CURVE     16
`define OC_F_RS        20
`define OC_F_TPICK     6
`define OC_F_TRST      12

// Reset values
`define OC_RST_WYE     1'b1
`define OC_RST_TCM     12'h555
`define OC_RES_IDX     5

`endif

// *** pkg/oc_pkg.sv ***
// Purpose: Types for the overcurrent element logic
// Assumes: oc_cfg.svh widths
// Notes:   None
`include "oc_cfg.svh"
package oc_pkg;
  typedef logic signed [`OC_EXT_W-1:0] ext_t;
  typedef logic [`OC_MAG_W-1:0]        mag_t;
  typedef logic [`OC_PU_W-1:0]         pu_t;
  typedef logic [`OC_ACC_W-1:0]        acc_t;
  typedef enum logic [1:0] {
    TC_ZERO = 2'h0,
    TC_ONE  = 2'h1,
    TC_EXT  = 2'h2
  } tc_mode_t;
endpackage

// *** pkg/toc_if.sv ***
// Purpose: Carrier between control logic and one inverse-time element
// Assumes: One pclk domain
// Notes:   Settings are static between ticks
`timescale 1ns/1ps
`include "oc_cfg.svh"
interface toc_if;
  logic                    tick;
  oc_pkg::mag_t            mag_sq;
  oc_pkg::mag_t            pu_sq;
  logic                    off;
  logic                    torque;
  logic [`OC_CURVE_W-1:0]  curve;
  logic [`OC_DIAL_W-1:0]   dial;
  logic                    disk;
  logic                    trip;
  logic                    pick;
  logic                    rst;
  modport ctrl (output tick, mag_sq, pu_sq, off, torque, curve, dial, disk,
                input  trip, pick, rst);
  modport elem (input  tick, mag_sq, pu_sq, off, torque, curve, dial, disk,
                output trip, pick, rst);
endinterface

// *** sim/overcurrent_element_logic_tb.sv ***
// Purpose: Self-checking bench for the overcurrent element logic
// Assumes: CYC_TICKS set to 4 for short runs
// Notes:   Outputs checked 4 edges after each sample, once status has settled
`timescale 1ns/1ps
`include "oc_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module overcurrent_element_logic_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, sample_valid, irq;
  logic signed [15:0] a = 0, b = 0, c = 0, ia_re, ia_im, ib_re, ib_im, ic_re, ic_im;
  logic [5:0] torque_ext = 6'h00, trip, pick, rst;
  logic [12:0] inst;
  int miscompares = 0, n_compared = 0, cycles = 0;
  always #10 pclk = ~pclk;
  phasor_source i_src (.pclk(pclk), .presetn(presetn), .run(run), .a(a), .b(b), .c(c),
    .sample_valid(sample_valid), .ia_re(ia_re), .ia_im(ia_im), .ib_re(ib_re), .ib_im(ib_im),
    .ic_re(ic_re), .ic_im(ic_im));
  overcurrent_element_logic #(.CYC_TICKS(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .ia_re(ia_re), .ia_im(ia_im),
    .ib_re(ib_re), .ib_im(ib_im), .ic_re(ic_re), .ic_im(ic_im), .torque_ext(torque_ext),
    .inst_out(inst), .inverse_time_trip_out(trip), .toc_pickup_out(pick),
    .inverse_time_reset_out(rst), .irq(irq));
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; psel <= 0; penable <= 0;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge sample_valid);
    // Status and irq land one edge after the outputs
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(0, `OC_A_CTRL, 0); `CHK(q, 32'h00000001)
    apb(0, `OC_A_TCMODE, 0); `CHK(q, 32'h00000555)
    apb(0, 8'hFC, 0); `CHK(pslverr, 1'b1)
    $display("test regs done");
  endtask
  task automatic t_inst;
    apb(1, `OC_A_IPU, 100); apb(1, 8'h18, 110); apb(1, 8'h20, 120); apb(1, 8'h3C, 50);
    apb(1, 8'h34, 80); apb(1, 8'h38, 90); apb(1, 8'h9C, 1);
    a <= 50; b <= 150; c <= 120; run <= 1; ticks(1);
    `CHK(inst[0], 1'b1)
    `CHK(inst[2:1], 2'h2)
    `CHK(inst[4:3], 2'h2)
    `CHK(inst[10:9], 2'h1)
    `CHK(inst[11], 1'b1)
    `CHK(irq, 1'b1)
    apb(0, `OC_A_INTST, 0); `CHK(q, 32'h00000A15)
    apb(0, `OC_A_INTST, 0); `CHK(q[0], 1'b0)
    apb(1, `OC_A_CTRL, 0); ticks(1); `CHK(inst[11], 1'b0)
    a <= 0; b <= 0; c <= 0; run <= 0; apb(1, `OC_A_CTRL, 1);
    $display("test inst done");
  endtask
  task automatic t_toc;
    apb(1, `OC_A_TPU, 100); apb(1, `OC_A_TSET, 32'h000F0001);
    a <= 101; run <= 1; ticks(15);
    `CHK({trip[0], pick[0], rst[0]}, 3'h2)
    ticks(1); `CHK(trip[0], 1'b1)
    a <= 0; ticks(3); `CHK({trip[0], rst[0]}, 2'h0)
    ticks(1); `CHK(rst[0], 1'b1)
    apb(1, `OC_A_TCMODE, 32'h554); a <= 101; ticks(2); `CHK(pick[0], 1'b0)
    apb(1, `OC_A_TCMODE, 32'h556); torque_ext <= 6'h01; ticks(1); `CHK(pick[0], 1'b1)
    apb(1, `OC_A_TSET, 32'h001F0001); ticks(16); a <= 0; ticks(4); `CHK(rst[0], 1'b0)
    $display("test toc done");
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_regs(); t_inst(); t_toc();
    close_out();
  end
endmodule // overcurrent_element_logic_tb

// *** sim/phasor_source.sv ***
// Purpose: Phasor source model for the measurement side
// Assumes: One phasor set every 4 pclk cycles while run is high
// Notes:   Idle phasor lines show inverted data, never a stale value
`timescale 1ns/1ps
`include "oc_cfg.svh"
module phasor_source (
  // Clock and control
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       run,
  // Real parts to send, imaginary parts zero
  input  wire logic signed [`OC_PH_W-1:0] a,
  input  wire logic signed [`OC_PH_W-1:0] b,
  input  wire logic signed [`OC_PH_W-1:0] c,
  // Phasor outputs
  output logic                            sample_valid,
  output logic signed [`OC_PH_W-1:0]      ia_re,
  output logic signed [`OC_PH_W-1:0]      ia_im,
  output logic signed [`OC_PH_W-1:0]      ib_re,
  output logic signed [`OC_PH_W-1:0]      ib_im,
  output logic signed [`OC_PH_W-1:0]      ic_re,
  output logic signed [`OC_PH_W-1:0]      ic_im
);
  logic [1:0] div;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div <= 2'h0;
    else div <= div + 2'h1;
  end
  // One set per interval, harmonics already stripped
  assign sample_valid = run && (div == 2'h3);
  assign ia_re = sample_valid ? a : ~a;
  assign ib_re = sample_valid ? b : ~b;
  assign ic_re = sample_valid ? c : ~c;
  assign ia_im = sample_valid ? 16'sh0000 : 16'shFFFF;
  assign ib_im = sample_valid ? 16'sh0000 : 16'shFFFF;
  assign ic_im = sample_valid ? 16'sh0000 : 16'shFFFF;
endmodule // phasor_source
